// ### verilog/mpsl_top.v
// Sixth-port MII transmit/receive path and power-on strap capture.
// Assumes tx/rx clocks come from the far side and are sampled on clk_in.
//
// Summary of operation
// - Sample transmit data bit 0 at reset as flow-control enable, default on.
// - After reset, bit-0 pin drives transmit data on transmit clock rise.
// - Transmit data bits 3 to 1 change on transmit clock rising edge.
// - Sample transmit-error pin at reset as port 4 fibre select, default twisted pair.
// - Outside reset, transmit-error pin signals transmit errors.
// - Duplex/collision LED strapped low drives active high, blinking on collision.
// - Duplex/collision LED strapped high drives active low, blinking on collision.
// - Transmit enable is an output; at reset it and LED pin form config strap.
// - Config strap 00 selects master mode reading configuration words 00h to 27h.
// - Without overrides: full duplex, 100M, flow control on, twisted pair.
`timescale 1ns/1ps
`include "mpsl_regs.vh"
module mpsl_top #(
	parameter BLINK_CYC = `MPSL_BLINK_CYC
) (
	// Clock, reset, enable
	input wire clk_in,
	input wire reset_in,
	input wire ce_in,
	// User transmit side
	input wire [3:0] user_txd_in,
	input wire user_txen_in,
	input wire user_txer_in,
	// User receive side
	output reg [3:0] user_rxd_out,
	output reg user_rxdv_out,
	output reg user_rx_stb_out,
	output reg user_tx_stb_out,
	// MII clocks from far side
	input wire mii_txclk_in,
	input wire mii_rxclk_in,
	// MII transmit pins, bit 0 and error/enable are two-way
	input wire txd0_in,
	output reg txd0_out,
	output reg txd0_oe_n_out,
	output reg [2:0] txd_hi_out,
	input wire txer_in,
	output reg txer_out,
	output reg txer_oe_n_out,
	input wire txen_in,
	output reg txen_out,
	output reg txen_oe_n_out,
	// MII receive pins
	input wire [3:0] mii_rxd_in,
	input wire mii_rxdv_in,
	// MII status inputs from far side
	input wire mii_half_duplex_in,
	input wire mii_link_fail_in,
	input wire mii_speed_ten_in,
	// Port 1 duplex/collision LED, two-way
	input wire port1_duplex_collision_led_in,
	output reg port1_duplex_collision_led_out,
	output reg port1_duplex_collision_led_oe_n_out,
	input wire port1_full_duplex_in,
	input wire port1_collision_in,
	// Captured straps and status
	output reg global_flow_ctrl_strap_out,
	output reg port4_fibre_strap_out,
	output reg cfg_source_strap_hi_out,
	output reg cfg_source_strap_lo_out,
	output reg cfg_master_out,
	output reg [7:0] cfg_bank_first_out,
	output reg [7:0] cfg_bank_last_out,
	output reg mii_full_duplex_out,
	output reg mii_speed_100_out,
	output reg mii_link_up_out
);

// ---------------------------------------------------------------
// Input synchronisers
// ---------------------------------------------------------------
localparam NSYNC = 14;
wire [NSYNC-1:0] raw_w;
reg [NSYNC-1:0] s1_r;
reg [NSYNC-1:0] s2_r;
assign raw_w = {mii_txclk_in, mii_rxclk_in, txd0_in, txer_in, txen_in,
	port1_duplex_collision_led_in, mii_rxd_in, mii_rxdv_in,
	mii_half_duplex_in, mii_link_fail_in, mii_speed_ten_in};
genvar gi;
generate
	for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
		// Runs through reset too, so straps are settled at release
		always @(posedge clk_in) begin
			if (ce_in) begin
				s1_r[gi] <= raw_w[gi];
				s2_r[gi] <= s1_r[gi];
			end
		end
	end
endgenerate
wire txclk_s = s2_r[13];
wire rxclk_s = s2_r[12];
wire txd0_s = s2_r[11];
wire txer_s = s2_r[10];
wire txen_s = s2_r[9];
wire led_s = s2_r[8];
wire [3:0] rxd_s = s2_r[7:4];
wire rxdv_s = s2_r[3];
wire half_s = s2_r[2];
wire lfail_s = s2_r[1];
wire ten_s = s2_r[0];

// ---------------------------------------------------------------
// Strap capture
// ---------------------------------------------------------------
// Pins must hold their straps two clocks before release
reg in_reset_r;
reg run_r;
reg led_pol_r;
always @(posedge clk_in) begin
	if (reset_in) begin
		in_reset_r <= 1'h1;
		run_r <= 1'h0;
		led_pol_r <= 1'h0;
		global_flow_ctrl_strap_out <= `MPSL_FC_ON;
		port4_fibre_strap_out <= 1'h0;
		cfg_source_strap_hi_out <= 1'h0;
		cfg_source_strap_lo_out <= 1'h0;
		cfg_master_out <= 1'h1;
	end else if (ce_in) begin
		if (in_reset_r) begin
			in_reset_r <= 1'h0;
			run_r <= 1'h1;
			global_flow_ctrl_strap_out <= txd0_s;
			port4_fibre_strap_out <= txer_s;
			cfg_source_strap_hi_out <= led_s;
			cfg_source_strap_lo_out <= txen_s;
			led_pol_r <= led_s;
			cfg_master_out <= ({led_s, txen_s} == `MPSL_CFG_MASTER);
		end
	end
end

always @(posedge clk_in) begin
	if (reset_in) begin
		cfg_bank_first_out <= `MPSL_BANK_FIRST;
		cfg_bank_last_out <= `MPSL_BANK_LAST;
	end else if (ce_in) begin
		cfg_bank_first_out <= `MPSL_BANK_FIRST;
		cfg_bank_last_out <= `MPSL_BANK_LAST;
	end
end

// ---------------------------------------------------------------
// MII status inputs
// ---------------------------------------------------------------
always @(posedge clk_in) begin
	if (reset_in) begin
		mii_full_duplex_out <= `MPSL_DEF_FULL;
		mii_speed_100_out <= `MPSL_DEF_100M;
		mii_link_up_out <= 1'h0;
	end else if (ce_in) begin
		mii_full_duplex_out <= ~half_s;
		mii_speed_100_out <= ~ten_s;
		mii_link_up_out <= ~lfail_s;
	end
end

// ---------------------------------------------------------------
// Link clock edge detection
// ---------------------------------------------------------------
reg txclk_d_r;
reg rxclk_d_r;
wire tx_rise = txclk_s & ~txclk_d_r;
wire rx_rise = rxclk_s & ~rxclk_d_r;
// clocks from far side
// Tracks the pin through reset too, so release shows no false edge
always @(posedge clk_in) begin
	if (ce_in) begin
		txclk_d_r <= txclk_s;
		rxclk_d_r <= rxclk_s;
	end
end

// ---------------------------------------------------------------
// Transmit path
// ---------------------------------------------------------------
always @(posedge clk_in) begin
	if (reset_in) begin
		txd0_out <= 1'h0;
		txd_hi_out <= 3'h0;
		txer_out <= 1'h0;
		txen_out <= 1'h0;
		txd0_oe_n_out <= 1'h1;
		txer_oe_n_out <= 1'h1;
		txen_oe_n_out <= 1'h1;
		user_tx_stb_out <= 1'h0;
	end else if (ce_in) begin
		user_tx_stb_out <= 1'h0;
		txd0_oe_n_out <= ~run_r;
		txer_oe_n_out <= ~run_r;
		txen_oe_n_out <= ~run_r;
		// Nibble goes out only once the pins are driven
		if (run_r && tx_rise) begin
			user_tx_stb_out <= 1'h1;
			txd0_out <= user_txd_in[0];
			txd_hi_out <= user_txd_in[3:1];
			txer_out <= user_txer_in;
			txen_out <= user_txen_in;
		end
	end
end

// ---------------------------------------------------------------
// Receive path
// ---------------------------------------------------------------
always @(posedge clk_in) begin
	if (reset_in) begin
		user_rxd_out <= 4'h0;
		user_rxdv_out <= 1'h0;
		user_rx_stb_out <= 1'h0;
	end else if (ce_in) begin
		user_rx_stb_out <= 1'h0;
		if (rx_rise) begin
			user_rxd_out <= rxd_s;
			user_rxdv_out <= rxdv_s;
			user_rx_stb_out <= run_r;
		end
	end
end

// ---------------------------------------------------------------
// Port 1 status synchronisers
// ---------------------------------------------------------------
reg full_s1_r;
reg full_s2_r;
reg col_s1_r;
reg col_s2_r;
always @(posedge clk_in) begin
	if (reset_in) begin
		full_s1_r <= 1'h0;
		full_s2_r <= 1'h0;
		col_s1_r <= 1'h0;
		col_s2_r <= 1'h0;
	end else if (ce_in) begin
		full_s1_r <= port1_full_duplex_in;
		full_s2_r <= full_s1_r;
		col_s1_r <= port1_collision_in;
		col_s2_r <= col_s1_r;
	end
end

// ---------------------------------------------------------------
// Collision blink timer
// ---------------------------------------------------------------
// Free-running, so a collision starts blinking at once
reg [20:0] blink_cnt_r;
reg blink_r;
always @(posedge clk_in) begin
	if (reset_in) begin
		blink_cnt_r <= 21'h0;
		blink_r <= 1'h0;
	end else if (ce_in) begin
		if (blink_cnt_r >= BLINK_CYC - 1) begin
			blink_cnt_r <= 21'h0;
			blink_r <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 21'h1;
		end
	end
end

// ---------------------------------------------------------------
// Port 1 duplex/collision LED
// ---------------------------------------------------------------
wire port1_collision_in_s = col_s2_r;
wire led_lvl = port1_collision_in_s ? blink_r : full_s2_r;
always @(posedge clk_in) begin
	if (reset_in) begin
		port1_duplex_collision_led_out <= 1'h0;
		port1_duplex_collision_led_oe_n_out <= 1'h1;
	end else if (ce_in) begin
		port1_duplex_collision_led_oe_n_out <= ~run_r;
		// Strap level 1 inverts the LED sense
		// active-high if strapped low
		port1_duplex_collision_led_out <= led_lvl ^ (led_pol_r == `MPSL_LED_ACT_LOW);
	end
end

endmodule

// ### verilog/mpsl_regs.vh
// Constants for the sixth-port MII and strap sampling block.
// Included by mpsl_top.v; definitions only.
`ifndef MPSL_REGS_VH
`define MPSL_REGS_VH
// Strap polarities
`define MPSL_FC_ON 1'h1
`define MPSL_FIBRE 1'h1
`define MPSL_LED_ACT_LOW 1'h1
// Configuration source codes
`define MPSL_CFG_MASTER 2'h0
// Serial configuration bank, first and last word
`define MPSL_BANK_FIRST 8'h00
`define MPSL_BANK_LAST 8'h27
// Collision blink half period in clock cycles (40 MHz, 50 ms)
`define MPSL_BLINK_MS 50
`define MPSL_BLINK_CYC 21'h1E8480
// Default link state when not strapped: full duplex, 100M
`define MPSL_DEF_FULL 1'h1
`define MPSL_DEF_100M 1'h1
`endif

// ### bench/mpsl_top_asserts.sv
// Concurrent checks on the MII port and strap block.
// Bound into mpsl_top; sees only its ports.
`timescale 1ns/1ps
module mpsl_top_asserts (
	// Clock, reset and far-side inputs
	input logic clk_in, reset_in, mii_txclk_in, mii_rxclk_in, mii_rxdv_in,
	input logic [3:0] mii_rxd_in,
	input logic port1_full_duplex_in, port1_collision_in,
	// Observed outputs
	input logic user_tx_stb_out, user_rx_stb_out, user_rxdv_out, txd0_out,
	input logic [3:0] user_rxd_out,
	input logic [2:0] txd_hi_out,
	input logic txd0_oe_n_out, txer_oe_n_out, txen_oe_n_out,
	input logic port1_duplex_collision_led_out, port1_duplex_collision_led_oe_n_out,
	input logic global_flow_ctrl_strap_out, port4_fibre_strap_out,
	input logic cfg_source_strap_hi_out, cfg_source_strap_lo_out, cfg_master_out,
	input logic [7:0] cfg_bank_first_out, cfg_bank_last_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_oe_in_reset: assert property (disable iff (1'b0) reset_in |=>
		txd0_oe_n_out && txer_oe_n_out && txen_oe_n_out) else $error("pin driven in reset");
	a_strap_hold: assert property (!$past(reset_in) && !$past(reset_in, 2) |->
		$stable({global_flow_ctrl_strap_out,
		port4_fibre_strap_out, cfg_source_strap_hi_out, cfg_source_strap_lo_out}))
		else $error("strap changed");
	a_cfg_master: assert property (cfg_master_out == !(cfg_source_strap_hi_out ||
		cfg_source_strap_lo_out) && cfg_bank_first_out == 8'h00 && cfg_bank_last_out == 8'h27)
		else $error("master decode wrong");
	a_tx_only_stb: assert property (!user_tx_stb_out |-> $stable({txd_hi_out, txd0_out}))
		else $error("tx data moved off strobe");
	a_tx_on_clock: assert property ($rose(mii_txclk_in) && !txd0_oe_n_out |->
		##[1:4] user_tx_stb_out) else $error("tx clock rise not served");
	a_rx_on_clock: assert property ($rose(mii_rxclk_in) && !txd0_oe_n_out |->
		##[1:4] user_rx_stb_out) else $error("rx clock rise not served");
	a_rx_nibble: assert property (user_rx_stb_out |-> user_rxd_out == $past(mii_rxd_in, 2)
		&& user_rxdv_out == $past(mii_rxdv_in, 2)) else $error("rx nibble wrong");
	a_led_level: assert property ((!port1_collision_in && $stable(port1_full_duplex_in))[*6]
		##0 !port1_duplex_collision_led_oe_n_out |-> port1_duplex_collision_led_out ==
		(port1_full_duplex_in ^ cfg_source_strap_hi_out)) else $error("led level wrong");
endmodule
bind mpsl_top mpsl_top_asserts mpsl_top_asserts_inst (.*);

// ### bench/mpsl_mii_partner.sv
// Far-side MII party: both clocks and the receive stream.
// Strap pins and status inputs come from the bench.
`timescale 1ns/1ps
module mpsl_mii_partner (
	// MII clocks and receive pins
	output logic txclk_out,
	output logic rxclk_out,
	output logic rxdv_out,
	output logic [3:0] rxd_out
);
	int n;
	initial begin
		txclk_out = 1'b0;
		forever #100 txclk_out = ~txclk_out;
	end
	initial begin
		rxclk_out = 1'b0;
		#37;
		forever #100 rxclk_out = ~rxclk_out;
	end
	// change on fall, stable at rise
	initial begin
		n = 0;
		rxd_out = 4'h0;
		rxdv_out = 1'b0;
		forever begin
			@(negedge rxclk_out);
			n++;
			rxd_out <= n[3:0] ^ 4'h5;
			rxdv_out <= (n % 12) < 8;
		end
	end
endmodule

// ### bench/mpsl_top_test.sv
// Self-checking bench for mpsl_top with the MII partner model.
// Strap pins resolve from pull values while the design is not driving.
`timescale 1ns/1ps
module mpsl_top_test;
	logic clk_in, reset_in, ce_in, user_txen_in, user_txer_in, txd0_in, txer_in, txen_in;
	logic [3:0] user_txd_in, user_rxd_out, mii_rxd_in, strap_r;
	logic user_rxdv_out, user_rx_stb_out, user_tx_stb_out, mii_txclk_in, mii_rxclk_in;
	logic mii_rxdv_in, txd0_out, txd0_oe_n_out, txer_out, txer_oe_n_out, txen_out, txen_oe_n_out;
	logic [2:0] txd_hi_out;
	logic mii_half_duplex_in, mii_link_fail_in, mii_speed_ten_in, led_prev_r;
	logic port1_duplex_collision_led_in, port1_duplex_collision_led_out;
	logic port1_duplex_collision_led_oe_n_out, port1_full_duplex_in, port1_collision_in;
	logic global_flow_ctrl_strap_out, port4_fibre_strap_out, cfg_source_strap_hi_out;
	logic cfg_source_strap_lo_out, cfg_master_out, mii_full_duplex_out, mii_speed_100_out;
	logic mii_link_up_out;
	logic [7:0] cfg_bank_first_out, cfg_bank_last_out;
	logic [4:0] rx_exp_r;
	// Straps and status in, strap and decode outputs expected
	logic [14:0] rows [4] = '{15'h408F, 15'h3F70, 15'h52A6, 15'h2D51};
	int fail_count = 0;
	int num_checks = 0;
	assign txd0_in = txd0_oe_n_out ? strap_r[3] : txd0_out;
	assign txer_in = txer_oe_n_out ? strap_r[2] : txer_out;
	assign port1_duplex_collision_led_in = port1_duplex_collision_led_oe_n_out ? strap_r[1] :
		port1_duplex_collision_led_out;
	assign txen_in = txen_oe_n_out ? strap_r[0] : txen_out;
	mpsl_top #(.BLINK_CYC(8)) mpsl_top_inst (.*);
	mpsl_mii_partner mpsl_mii_partner_inst (.txclk_out(mii_txclk_in), .rxclk_out(mii_rxclk_in),
		.rxdv_out(mii_rxdv_in), .rxd_out(mii_rxd_in));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge mii_rxclk_in) rx_exp_r <= {mii_rxdv_in, mii_rxd_in};
	task chk(input logic ok, input string msg);
		#1;
		num_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task wait_stb(input logic rx);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while ((rx ? user_rx_stb_out : user_tx_stb_out) !== 1'b1 && n < 80);
		chk(n < 80, "strobe timeout");
		if (n == 80) print_verdict();
	endtask
	initial begin
		{reset_in, ce_in, strap_r, user_txd_in, user_txen_in, user_txer_in} = 12'hE00;
		{mii_half_duplex_in, mii_link_fail_in, mii_speed_ten_in} = 3'h0;
		{port1_full_duplex_in, port1_collision_in} = 2'h0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			reset_in <= 1'b1;
			{strap_r, mii_half_duplex_in, mii_link_fail_in, mii_speed_ten_in} <= rows[i][14:8];
			repeat (6) @(posedge clk_in);
			reset_in <= 1'b0;
			repeat (8) @(posedge clk_in);
			chk({global_flow_ctrl_strap_out, port4_fibre_strap_out, cfg_source_strap_hi_out,
				cfg_source_strap_lo_out, cfg_master_out, mii_full_duplex_out, mii_speed_100_out,
				mii_link_up_out} === rows[i][7:0], "strap row");
			chk(cfg_bank_first_out === 8'h00 && cfg_bank_last_out === 8'h27, "bank");
			chk(port1_duplex_collision_led_out === rows[i][12], "led idle");
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_in);
			{user_txd_in, user_txen_in, user_txer_in} <= k ? 6'h16 : 6'h2B;
			wait_stb(1'b0);
			wait_stb(1'b0);
			chk({txd_hi_out, txd0_out, txen_out, txer_out, txd0_oe_n_out} ===
				(k ? 7'h2C : 7'h56), "tx nibble");
		end
		repeat (12) begin
			wait_stb(1'b1);
			chk({user_rxdv_out, user_rxd_out} === rx_exp_r, "rx nibble");
		end
		@(posedge clk_in);
		port1_full_duplex_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk(port1_duplex_collision_led_out === 1'b1, "led full");
		@(posedge clk_in);
		port1_collision_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		#1;
		led_prev_r = port1_duplex_collision_led_out;
		repeat (8) @(posedge clk_in);
		chk(port1_duplex_collision_led_out === ~led_prev_r, "led blink");
		print_verdict();
	end
endmodule
